// file: eq_store_recall_pkg.sv
// Constants, bus carrier and state types for the equalizer store and recall block.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package eq_store_recall_pkg;

   //---------------------------------------------------------------------------
   // Sizes and timing.
   //---------------------------------------------------------------------------
   localparam int LANE_COUNT = 4;
   localparam int PATH_COUNT = 2;
   localparam int EQ_W = 8;
   localparam int SEL_W = 4;
   localparam int ADDR_W = 6;
   localparam int RECALL_BUF_COUNT = 3;
   localparam int CLK_PERIOD_NS = 50;
   localparam int TRANS_TIME_NS = 1000;
   localparam int TRANS_CYCLES = (TRANS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STORE_CYCLES = 2;

   //---------------------------------------------------------------------------
   // Register byte offsets.
   //---------------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CAP = 6'h00;
   localparam logic [ADDR_W-1:0] OFF_LANE_CTRL = 6'h04;
   localparam logic [ADDR_W-1:0] OFF_STORE = 6'h08;
   localparam logic [ADDR_W-1:0] OFF_RECALL0 = 6'h0c;
   localparam logic [ADDR_W-1:0] OFF_RECALL1 = 6'h10;
   localparam logic [ADDR_W-1:0] OFF_APPLY = 6'h14;
   localparam logic [ADDR_W-1:0] OFF_RECALLED = 6'h18;
   localparam logic [ADDR_W-1:0] OFF_MOD_CTRL = 6'h1c;
   localparam logic [ADDR_W-1:0] OFF_PATH_CTRL = 6'h20;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h24;
   localparam logic [ADDR_W-1:0] OFF_EQ_VALUE = 6'h28;

   //---------------------------------------------------------------------------
   // Field positions and reset values.
   //---------------------------------------------------------------------------
   localparam int ENABLE_LSB = 0;
   localparam int FREEZE_LSB = 8;
   localparam int OVERRIDE_LSB = 16;
   localparam int APPLY_REINIT_LSB = 0;
   localparam int APPLY_NOW_LSB = 4;
   localparam int LOWPWR_BIT = 0;
   localparam int SWRESET_BIT = 1;
   localparam int PATH_INIT_LSB = 0;
   localparam int PATH_ACT_LSB = 8;
   localparam int STAT_PATH_LSB = 8;
   localparam logic [31:0] RST_MOD_CTRL = 32'h0000_0001;

   //---------------------------------------------------------------------------
   // State enumerations and the Avalon-MM request carrier.
   //---------------------------------------------------------------------------
   typedef enum logic [2:0] {
      MOD_RESET, MOD_MGMT_INIT, MOD_LOW_PWR, MOD_PWR_UP, MOD_READY, MOD_PWR_DN, MOD_FAULT
   } module_state_e;

   typedef enum logic [2:0] {
      PATH_DEACTIVATED, PATH_INITIALIZING, PATH_INITIALIZED_STATE, PATH_ACTIVATING,
      PATH_ACTIVATED_STATE, PATH_DEINIT
   } path_state_e;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avm_req_s;

endpackage : eq_store_recall_pkg

// file: adaptive_eq_store_recall.sv
// Per-lane adaptive equalizer store and recall with module and path state machines.
`timescale 1ns/1ps
module adaptive_eq_store_recall #(
   parameter int LANES = eq_store_recall_pkg::LANE_COUNT,
   parameter int PATHS = eq_store_recall_pkg::PATH_COUNT,
   parameter int RECALL_BUFS = eq_store_recall_pkg::RECALL_BUF_COUNT
) (
   input wire logic mclk,
   input wire logic rst,
   input wire eq_store_recall_pkg::avm_req_s busReq,
   output logic busWaitrequest,
   output logic [31:0] busReaddata,
   input wire logic faultIn,
   input wire logic [LANES-1:0][eq_store_recall_pkg::EQ_W-1:0] adaptTarget,
   output logic [LANES-1:0][eq_store_recall_pkg::EQ_W-1:0] eqSetting,
   output logic [LANES-1:0] adaptRun
);
   import eq_store_recall_pkg::*;

   localparam int LPP = LANES / PATHS;

   //---------------------------------------------------------------------------
   // Whole module state.
   //---------------------------------------------------------------------------
   typedef struct packed {
      module_state_e modState;
      path_state_e [PATHS-1:0] pathState;
      logic [7:0] modCnt;
      logic [PATHS-1:0][7:0] pathCnt;
      logic [31:0] laneCtrl;
      logic [31:0] modCtrl;
      logic [31:0] pathCtrl;
      logic [1:0][31:0] recallReg;
      logic [LANES-1:0][SEL_W-1:0] recalled;
      logic [LANES-1:0][EQ_W-1:0] eq;
      logic [LANES-1:0] storing;
      logic [LANES-1:0][SEL_W-1:0] storeBuf;
      logic [LANES-1:0][1:0] storeCnt;
      logic [RECALL_BUFS-1:0][LANES-1:0][EQ_W-1:0] mem;
      logic ack;
      logic [31:0] rdata;
   } state_s;

   state_s s_q;
   state_s s_d;
   logic wrFire;
   logic [31:0] storeWord;
   logic [31:0] applyWord;
   logic [1:0] applyFire;
   logic softReset;
   logic [SEL_W-1:0] sel;

   //---------------------------------------------------------------------------
   // Helpers.
   //---------------------------------------------------------------------------
   // Merges write data into an old word under the byte enables.
   function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction : beMerge

   // True on the last cycle of a bounded transient state.
   function automatic logic timerDone(input logic [7:0] c);
      return c == 8'(TRANS_CYCLES - 1);
   endfunction : timerDone

   // True for a buffer number that names an implemented buffer.
   function automatic logic bufValid(input logic [SEL_W-1:0] b);
      return (b != '0) && (int'(b) <= RECALL_BUFS);
   endfunction : bufValid

   // True when a path state accepts immediate stores.
   function automatic logic pathLive(input path_state_e p);
      return (p == PATH_INITIALIZED_STATE) || (p == PATH_ACTIVATED_STATE);
   endfunction : pathLive

   //---------------------------------------------------------------------------
   // Outputs. Adaptation runs only while enabled, unfrozen, not storing and ready.
   //---------------------------------------------------------------------------
   assign busWaitrequest = (busReq.read | busReq.write) & ~s_q.ack;
   assign busReaddata = s_q.rdata;
   assign eqSetting = s_q.eq;
   always_comb begin
      for (int l = 0; l < LANES; l++) begin
         adaptRun[l] = s_q.laneCtrl[ENABLE_LSB + l] & ~s_q.laneCtrl[FREEZE_LSB + l] &
                       ~s_q.storing[l] & (s_q.modState == MOD_READY);
      end
   end

   //---------------------------------------------------------------------------
   // Next-state logic: bus slave, state machines, lanes.
   //---------------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      sel = '0;
      wrFire = busReq.write & s_q.ack;
      storeWord = '0;
      applyWord = '0;
      softReset = 1'b0;
      s_d.ack = (busReq.read | busReq.write) & ~s_q.ack;
      // Read data is captured in the wait cycle and stands at the completing edge.
      if (busReq.read && !s_q.ack) begin
         if (busReq.address == OFF_CAP) begin
            s_d.rdata = 32'(RECALL_BUFS);
         end else if (busReq.address == OFF_LANE_CTRL) begin
            s_d.rdata = s_q.laneCtrl;
         end else if (busReq.address == OFF_RECALL0) begin
            s_d.rdata = s_q.recallReg[0];
         end else if (busReq.address == OFF_RECALL1) begin
            s_d.rdata = s_q.recallReg[1];
         end else if (busReq.address == OFF_RECALLED) begin
            s_d.rdata = 32'(s_q.recalled);
         end else if (busReq.address == OFF_MOD_CTRL) begin
            s_d.rdata = s_q.modCtrl;
         end else if (busReq.address == OFF_PATH_CTRL) begin
            s_d.rdata = s_q.pathCtrl;
         end else if (busReq.address == OFF_STATUS) begin
            s_d.rdata = 32'(s_q.modState) | (32'(s_q.pathState) << STAT_PATH_LSB);
         end else if (busReq.address == OFF_EQ_VALUE) begin
            s_d.rdata = 32'(s_q.eq);
         end else begin
            s_d.rdata = '0;
         end
      end
      // Writes take effect at the edge where waitrequest is low; triggers read as zero.
      if (wrFire) begin
         if (busReq.address == OFF_LANE_CTRL) begin
            s_d.laneCtrl = beMerge(s_q.laneCtrl, busReq.writedata, busReq.byteenable);
         end else if (busReq.address == OFF_STORE) begin
            storeWord = beMerge('0, busReq.writedata, busReq.byteenable);
         end else if (busReq.address == OFF_RECALL0) begin
            s_d.recallReg[0] = beMerge(s_q.recallReg[0], busReq.writedata, busReq.byteenable);
         end else if (busReq.address == OFF_RECALL1) begin
            s_d.recallReg[1] = beMerge(s_q.recallReg[1], busReq.writedata, busReq.byteenable);
         end else if (busReq.address == OFF_APPLY) begin
            applyWord = beMerge('0, busReq.writedata, busReq.byteenable);
         end else if (busReq.address == OFF_MOD_CTRL) begin
            s_d.modCtrl = beMerge(s_q.modCtrl, busReq.writedata, busReq.byteenable);
            softReset = s_d.modCtrl[SWRESET_BIT];
         end else if (busReq.address == OFF_PATH_CTRL) begin
            s_d.pathCtrl = beMerge(s_q.pathCtrl, busReq.writedata, busReq.byteenable);
         end
      end
      for (int k = 0; k < 2; k++) begin
         applyFire[k] = applyWord[APPLY_REINIT_LSB + k] | applyWord[APPLY_NOW_LSB + k];
      end
      // The single module-wide machine; fault outranks all but reset.
      s_d.modCnt = s_q.modCnt + 8'd1;
      case (s_q.modState)
         MOD_RESET: begin
            s_d.modState = MOD_MGMT_INIT;
            s_d.modCnt = '0;
         end
         MOD_MGMT_INIT, MOD_PWR_UP, MOD_PWR_DN: begin
            if (timerDone(s_q.modCnt)) begin
               s_d.modState = (s_q.modState == MOD_PWR_UP) ? MOD_READY : MOD_LOW_PWR;
            end
         end
         MOD_LOW_PWR: begin
            if (!s_q.modCtrl[LOWPWR_BIT]) begin
               s_d.modState = MOD_PWR_UP;
               s_d.modCnt = '0;
            end
         end
         MOD_READY: begin
            if (s_q.modCtrl[LOWPWR_BIT]) begin
               s_d.modState = MOD_PWR_DN;
               s_d.modCnt = '0;
            end
         end
         default: begin
            s_d.modState = MOD_FAULT;
         end
      endcase
      if (faultIn && s_q.modState != MOD_RESET) begin
         s_d.modState = MOD_FAULT;
      end
      // One independent path machine per path, PATHS per instance, run only in the ready state.
      for (int p = 0; p < PATHS; p++) begin
         s_d.pathCnt[p] = s_q.pathCnt[p] + 8'd1;
         if (s_q.modState != MOD_READY) begin
            s_d.pathState[p] = PATH_DEACTIVATED;
         end else if (!s_q.pathCtrl[PATH_INIT_LSB + p] && s_q.pathState[p] != PATH_DEACTIVATED
                      && s_q.pathState[p] != PATH_DEINIT) begin
            s_d.pathState[p] = PATH_DEINIT;
            s_d.pathCnt[p] = '0;
         end else begin
            case (s_q.pathState[p])
               PATH_DEACTIVATED: begin
                  if (s_q.pathCtrl[PATH_INIT_LSB + p]) begin
                     s_d.pathState[p] = PATH_INITIALIZING;
                     s_d.pathCnt[p] = '0;
                  end
               end
               PATH_INITIALIZING: begin
                  if (timerDone(s_q.pathCnt[p])) begin
                     s_d.pathState[p] = PATH_INITIALIZED_STATE;
                  end
               end
               PATH_INITIALIZED_STATE: begin
                  if (s_q.pathCtrl[PATH_ACT_LSB + p]) begin
                     s_d.pathState[p] = PATH_ACTIVATING;
                     s_d.pathCnt[p] = '0;
                  end
               end
               PATH_ACTIVATING: begin
                  if (timerDone(s_q.pathCnt[p])) begin
                     s_d.pathState[p] = PATH_ACTIVATED_STATE;
                  end
               end
               PATH_ACTIVATED_STATE: begin
                  if (!s_q.pathCtrl[PATH_ACT_LSB + p]) begin
                     s_d.pathState[p] = PATH_INITIALIZED_STATE;
                  end
               end
               default: begin
                  if (timerDone(s_q.pathCnt[p])) begin
                     s_d.pathState[p] = PATH_DEACTIVATED;
                  end
               end
            endcase
            // A reinitializing apply reruns initialization of a live path.
            if ((applyWord[APPLY_REINIT_LSB] | applyWord[APPLY_REINIT_LSB + 1]) &&
                pathLive(s_q.pathState[p])) begin
               s_d.pathState[p] = PATH_INITIALIZING;
               s_d.pathCnt[p] = '0;
            end
         end
      end
      // Per-lane adaptation, store progress, store launch and recall.
      for (int l = 0; l < LANES; l++) begin
         if (adaptRun[l]) begin
            if (s_q.eq[l] < adaptTarget[l]) begin
               s_d.eq[l] = EQ_W'(s_q.eq[l] + 1'b1);
            end else if (s_q.eq[l] > adaptTarget[l]) begin
               s_d.eq[l] = EQ_W'(s_q.eq[l] - 1'b1);
            end
         end
         if (s_q.storing[l]) begin
            s_d.storeCnt[l] = s_q.storeCnt[l] + 2'd1;
            if (s_q.storeCnt[l] == 2'(STORE_CYCLES - 1)) begin
               s_d.mem[int'(s_q.storeBuf[l]) - 1][l] = s_q.eq[l];
               s_d.storing[l] = 1'b0;
            end
         end else if (storeWord[SEL_W*l +: SEL_W] != '0 && s_q.laneCtrl[ENABLE_LSB + l] &&
                      bufValid(storeWord[SEL_W*l +: SEL_W]) &&
                      pathLive(s_q.pathState[l / LPP])) begin
            s_d.storing[l] = 1'b1;
            s_d.storeBuf[l] = storeWord[SEL_W*l +: SEL_W];
            s_d.storeCnt[l] = '0;
         end
         // Recall goes to the equalizer only on an apply; the override bit is not consulted.
         for (int k = 0; k < 2; k++) begin
            sel = s_q.recallReg[k][SEL_W*l +: SEL_W];
            if (applyFire[k] && bufValid(sel) && s_q.laneCtrl[ENABLE_LSB + l] &&
                !s_q.storing[l]) begin
               s_d.eq[l] = s_q.mem[int'(sel) - 1][l];
               s_d.recalled[l] = sel;
            end
         end
      end
      if (softReset) begin
         s_d = '0;
         s_d.modCtrl = RST_MOD_CTRL;
      end
   end

   //---------------------------------------------------------------------------
   // State register.
   //---------------------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.modCtrl <= RST_MOD_CTRL;
      end else begin
         s_q <= s_d;
      end
   end

   //---------------------------------------------------------------------------
   // Checks and covers.
   //---------------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_store_pauses_adapt: assert property (!(|(s_q.storing & adaptRun)))
      else $error("adaptation ran during a store");
   a_store_disabled_lane: assert property (
      (wrFire && busReq.address == OFF_STORE && busReq.byteenable[0] &&
       !s_q.laneCtrl[ENABLE_LSB] && !s_q.storing[0]) |=> !s_q.storing[0])
      else $error("store accepted on a disabled lane");
   a_store_two_cycles: assert property (
      $rose(s_q.storing[0]) |-> ##1 s_q.storing[0] ##1 !s_q.storing[0])
      else $error("store did not last two cycles");
   a_store_copies_eq: assert property (
      (s_q.storing[0] && s_q.storeCnt[0] == 2'd1) |=>
      s_q.mem[int'($past(s_q.storeBuf[0])) - 1][0] == $past(s_q.eq[0]))
      else $error("stored value differs from lane setting");
   a_store_path_state: assert property (
      $rose(s_q.storing[0]) |-> pathLive($past(s_q.pathState[0])) && bufValid(s_q.storeBuf[0]))
      else $error("store launched in wrong path state or bad buffer");
   // A soft reset returns the whole state to its reset values, so it is excluded from the hold checks.
   a_recall_on_apply: assert property (
      (!(|applyFire) && !softReset) |=> $stable(s_q.recalled))
      else $error("recalled status changed without apply");
   a_frozen_holds: assert property (
      (s_q.laneCtrl[FREEZE_LSB] && !(|applyFire) && !softReset) |=> $stable(s_q.eq[0]))
      else $error("frozen lane setting moved");
   a_cap_reads_count: assert property (
      (busReq.read && s_q.ack && busReq.address == OFF_CAP) |-> busReaddata == 32'(RECALL_BUFS))
      else $error("capability read wrong");
   a_transient_bound: assert property (
      (s_q.modState == MOD_PWR_UP) |-> s_q.modCnt < 8'(TRANS_CYCLES))
      else $error("transient state overran its bound");
   a_wait_one_cycle: assert property ((busReq.read || busReq.write) && !s_q.ack |=>
      !busWaitrequest)
      else $error("bus answer late");

   c_store_done: cover property ($fell(s_q.storing[0]));
   c_recall_applied: cover property (|applyFire ##1 $changed(s_q.recalled));
   c_path_activated: cover property (s_q.pathState[0] == PATH_ACTIVATED_STATE);

endmodule : adaptive_eq_store_recall

// file: host_bus_model.sv
// Host management master model that drives the Avalon-MM register bus.
`timescale 1ns/1ps
module host_bus_model (
   input wire logic mclk,
   output eq_store_recall_pkg::avm_req_s busReq,
   input wire logic busWaitrequest,
   input wire logic [31:0] busReaddata
);
   import eq_store_recall_pkg::*;

   //---------------------------------------------------------------------------
   // Bus cycles
   //---------------------------------------------------------------------------
   // The bus is idle from time zero.
   initial busReq = '0;

   // One transfer: the request is held until waitrequest is seen low at a rising edge.
   // Read data is taken at that same edge, and only then is the request dropped.
   // Released address and data show the inverse of their last value, not stale data.
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge mclk);
      busReq <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
      do @(posedge mclk); while (busWaitrequest !== 1'b0);
      q = busReaddata;
      busReq <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d, byteenable: 4'h0};
   endtask : xfer
endmodule : host_bus_model

// file: tb.sv
// Self-checking testbench for the equalizer store and recall block.
`timescale 1ns/1ps
module tb;
   import eq_store_recall_pkg::*;
   typedef struct packed {logic [ADDR_W-1:0] a; logic [31:0] e;} row_s;
   logic mclk;
   logic rst;
   logic faultIn;
   avm_req_s busReq;
   logic busWaitrequest;
   logic [31:0] busReaddata;
   logic [LANE_COUNT-1:0][EQ_W-1:0] adaptTarget;
   logic [LANE_COUNT-1:0][EQ_W-1:0] eqSetting;
   logic [LANE_COUNT-1:0] adaptRun;
   logic [31:0] q;
   logic [31:0] d;
   int nFail = 0;
   int checkCount = 0;
   // Register values right after reset, including an unmapped and an unaligned place.
   row_s rows [8] = '{'{OFF_CAP, 32'(RECALL_BUF_COUNT)}, '{OFF_STORE, 32'h0},
      '{OFF_APPLY, 32'h0}, '{OFF_MOD_CTRL, RST_MOD_CTRL}, '{OFF_STATUS, 32'h2},
      '{OFF_EQ_VALUE, 32'h0}, '{6'h2c, 32'h0}, '{6'h01, 32'h0}};

   adaptive_eq_store_recall #(.RECALL_BUFS(RECALL_BUF_COUNT)) u_adaptive_eq_store_recall (
      .mclk(mclk), .rst(rst), .busReq(busReq), .busWaitrequest(busWaitrequest),
      .busReaddata(busReaddata), .faultIn(faultIn), .adaptTarget(adaptTarget),
      .eqSetting(eqSetting), .adaptRun(adaptRun));
   host_bus_model u_host_bus_model (.mclk(mclk), .busReq(busReq),
      .busWaitrequest(busWaitrequest), .busReaddata(busReaddata));

   //---------------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------------
   // Counts every comparison and reports a mismatch at once.
   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      checkCount++;
      if (g !== e) begin
         nFail++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk32
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      logic [31:0] x;
      u_host_bus_model.xfer(1'b1, a, v, x);
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
      u_host_bus_model.xfer(1'b0, a, 32'h0, v);
   endtask : rd
   // Reads status until a 3-bit state field matches; the read count bounds the wait.
   task automatic poll(input int sh, input logic [2:0] e, output logic [31:0] v);
      int n;
      n = 0;
      do begin
         rd(OFF_STATUS, v);
         n++;
      end while (v[sh+:3] !== e && n < 20);
   endtask : poll
   // Reports whether adaptation on one lane paused during the next four cycles.
   task automatic seeDrop(input int l, output logic [31:0] v);
      v = 32'h0;
      repeat (4) @(negedge mclk) if (adaptRun[l] === 1'b0) v = 32'h1;
   endtask : seeDrop
   task automatic finishTest();
      $display("checks %0d mismatches %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finishTest

   //---------------------------------------------------------------------------
   // Clock, watchdog and test sequence
   //---------------------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // A hang counts as a mismatch and ends the run the normal way.
   initial begin
      #2000000;
      nFail++;
      finishTest();
   end
   initial begin
      rst = 1'b1;
      faultIn = 1'b0;
      adaptTarget = '0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (25) @(posedge mclk);
      // Table of reset values and trigger read-back.
      foreach (rows[i]) begin
         rd(rows[i].a, q);
         chk32(q, rows[i].e);
      end
      // Bring the module up, then one path only; the other path must stay idle.
      adaptTarget <= {4{8'h40}};
      wr(OFF_LANE_CTRL, 32'h0002_000f);
      wr(OFF_MOD_CTRL, 32'h0);
      poll(0, 3'd4, q);
      chk32(32'(q[2:0]), 32'h4);
      wr(OFF_PATH_CTRL, 32'h1);
      poll(STAT_PATH_LSB, 3'd2, q);
      chk32(32'(q[10:8]), 32'h2);
      chk32(32'(q[13:11]), 32'h0);
      // Store on a lane whose path is not initialized is dropped.
      wr(OFF_STORE, 32'h0000_0100);
      seeDrop(2, d);
      chk32(d, 32'h0);
      wr(OFF_PATH_CTRL, 32'h101);
      poll(STAT_PATH_LSB, 3'd4, q);
      chk32(32'(q[10:8]), 32'h4);
      repeat (70) @(posedge mclk);
      chk32(32'(eqSetting[0]), 32'h40);
      // A buffer number above the count is dropped, a good one pauses adaptation.
      wr(OFF_STORE, 32'h4);
      seeDrop(0, d);
      chk32(d, 32'h0);
      wr(OFF_STORE, 32'h21);
      seeDrop(0, d);
      chk32(d, 32'h1);
      chk32(32'(adaptRun[0]), 32'h1);
      adaptTarget <= {4{8'hc0}};
      repeat (140) @(posedge mclk);
      chk32(32'(eqSetting[0]), 32'hc0);
      // Freeze lane 0, stage recalls, and see nothing move before the apply.
      wr(OFF_LANE_CTRL, 32'h0002_010f);
      wr(OFF_RECALL0, 32'h21);
      repeat (4) @(posedge mclk);
      chk32(32'(eqSetting[0]), 32'hc0);
      chk32(32'(eqSetting[1]), 32'hc0);
      wr(OFF_APPLY, 32'h10);
      repeat (2) @(negedge mclk);
      chk32(32'(eqSetting[0]), 32'h40);
      chk32(32'(eqSetting[1] < 8'h48), 32'h1);
      rd(OFF_RECALLED, q);
      chk32(q, 32'h21);
      repeat (140) @(posedge mclk);
      chk32(32'(eqSetting[0]), 32'h40);
      chk32(32'(eqSetting[1]), 32'hc0);
      // A store on a disabled lane is dropped; set 1 recalls other buffers on a reinit apply.
      wr(OFF_LANE_CTRL, 32'h0002_010e);
      wr(OFF_STORE, 32'h3);
      wr(OFF_LANE_CTRL, 32'h0002_010f);
      wr(OFF_RECALL1, 32'h13);
      chk32(32'(eqSetting[0]), 32'h40);
      wr(OFF_APPLY, 32'h2);
      @(negedge mclk);
      chk32(32'(eqSetting[0]), 32'h0);
      rd(OFF_RECALLED, q);
      chk32(q, 32'h13);
      rd(OFF_STATUS, q);
      chk32(32'(q[10:8]), 32'h1);
      // A fault is a steady state that outlives its cause and stops adaptation.
      faultIn <= 1'b1;
      repeat (3) @(posedge mclk);
      faultIn <= 1'b0;
      repeat (5) @(posedge mclk);
      rd(OFF_STATUS, q);
      chk32(32'(q[2:0]), 32'h6);
      chk32(32'(q[10:8]), 32'h0);
      chk32(32'(adaptRun), 32'h0);
      // A second reset in mid-run returns to the reset values.
      rst <= 1'b1;
      repeat (2) @(negedge mclk);
      chk32(32'(eqSetting), 32'h0);
      @(posedge mclk);
      rst <= 1'b0;
      repeat (25) @(posedge mclk);
      rd(OFF_STATUS, q);
      chk32(q, 32'h2);
      finishTest();
   end
endmodule : tb
